// File: hw/csf_alu_flags.sv
// 8-bit alu with zero, digit carry and carry generation
// assumes operands are stable within the cycle; purely combinational
`timescale 1ns/1ps
module csf_alu_flags
    import csf_pkg::*;
(
    input wire logic [csf_pkg::DATA_W-1:0] a,
    input wire logic [csf_pkg::DATA_W-1:0] b,
    input wire csf_pkg::csf_alu_op_t op,
    output logic [csf_pkg::DATA_W-1:0] result,
    output csf_pkg::csf_flags_t flags
);
    logic [DATA_W-1:0] b_eff;
    logic cin;
    logic [DATA_W:0] sum;
    logic [NIBBLE_W:0] nib;

    always_comb begin
        // subtraction as a + ~b + 1 so carry reads as inverted borrow
        b_eff = (op == CSF_OP_SUB) ? ~b : b;
        cin = (op == CSF_OP_SUB);
        sum = {1'b0, a} + {1'b0, b_eff} + {{DATA_W{1'b0}}, cin};
        nib = {1'b0, a[NIBBLE_W-1:0]} + {1'b0, b_eff[NIBBLE_W-1:0]}
            + {{NIBBLE_W{1'b0}}, cin};
        unique case (op)
            CSF_OP_ADD: result = sum[DATA_W-1:0];
            CSF_OP_SUB: result = sum[DATA_W-1:0];
            CSF_OP_AND: result = a & b;
            CSF_OP_IOR: result = a | b;
            CSF_OP_XOR: result = a ^ b;
            CSF_OP_PASS: result = a;
            default: result = a;
        endcase
        flags.zero = (result == '0);
        // carry out of the top bit and of the low nibble
        flags.carry = sum[DATA_W];
        flags.digit_carry = nib[NIBBLE_W];
    end

endmodule : csf_alu_flags

// File: hw/csf_pkg.sv
// shared types and constants for the cpu status flag register
// assumes one core clock and a synchronous active-high reset
package csf_pkg;

    localparam int DATA_W = 8;
    localparam int NIBBLE_W = 4;
    localparam int DIRECT_OFF_W = 7;
    localparam int INDIRECT_PTR_W = 8;
    localparam int BANK_ADDR_W = 9;

    // bit positions inside the status byte
    localparam int IBS_POS = 7;
    localparam int RP_HI_POS = 6;
    localparam int RP_LO_POS = 5;
    localparam int TMO_POS = 4;
    localparam int PWD_POS = 3;
    localparam int Z_POS = 2;
    localparam int DGC_POS = 1;
    localparam int C_POS = 0;

    // time-out and power-down read 1 after power-up; others cleared
    localparam logic [DATA_W-1:0] STATUS_RESET = 8'h18;
    localparam logic [DATA_W-1:0] CLEAR_VALUE = 8'h00;

    typedef struct packed {
        logic indirect_bank_select;
        logic direct_bank_select_hi;
        logic direct_bank_select_lo;
        logic timeout_flag;
        logic powerdown_flag;
        logic zero_flag;
        logic digit_carry_flag;
        logic carry_flag;
    } csf_status_t;

    typedef struct packed {
        logic zero;
        logic digit_carry;
        logic carry;
    } csf_flags_t;

    typedef struct packed {
        logic power_up;
        logic wdt_clear;
        logic sleep;
        logic wdt_timeout;
    } csf_cause_t;

    typedef enum logic [2:0] {
        CSF_OP_ADD,
        CSF_OP_SUB,
        CSF_OP_AND,
        CSF_OP_IOR,
        CSF_OP_XOR,
        CSF_OP_PASS
    } csf_alu_op_t;

endpackage : csf_pkg

// File: hw/csf_status_reg.sv
// status register of an 8-bit core: alu flags, reset cause, bank select
// assumes the core decodes instructions and drives the strobes below
// for one cycle per executed instruction, all on ref_clk
`timescale 1ns/1ps

// How it works
// - 7 indirect bank, 6-5 direct bank, 4-3 reset cause, 2-0 alu flags.
// - any instruction may write its result into the status register.
// - updated flags take the alu flags, not the written data.
// - time-out and power-down bits ignore every instruction write.
// - clear-file zeroes top three bits, sets zero, keeps the other bits.
// - in subtraction carry and digit carry are inverted borrows.
// - two direct bank bits pick one of four 128-byte banks.
// - carry is 1 exactly when the top bit carried out.
module csf_status_reg
    import csf_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [csf_pkg::DATA_W-1:0] alu_a,
    input wire logic [csf_pkg::DATA_W-1:0] alu_b,
    input wire csf_pkg::csf_alu_op_t alu_op,
    input wire csf_pkg::csf_flags_t flag_upd,
    input wire logic dest_status,
    input wire logic clear_file_instr,
    input wire csf_pkg::csf_cause_t cause,
    input wire logic [csf_pkg::DIRECT_OFF_W-1:0] direct_offset,
    input wire logic [csf_pkg::INDIRECT_PTR_W-1:0] indirect_ptr,
    output csf_pkg::csf_status_t cpu_status_q,
    output logic [csf_pkg::DATA_W-1:0] alu_result,
    output csf_pkg::csf_flags_t alu_flags,
    output logic [csf_pkg::BANK_ADDR_W-1:0] direct_addr,
    output logic [csf_pkg::BANK_ADDR_W-1:0] indirect_addr
);
    import csf_pkg::*;

    csf_status_t cpu_status_d;
    csf_status_t wr_val;
    csf_flags_t new_flags;
    csf_flags_t upd_mask;
    logic wr_en;

    csf_alu_flags u_alu (
        .a(alu_a),
        .b(alu_b),
        .op(alu_op),
        .result(alu_result),
        .flags(alu_flags)
    );

    always_comb begin
        wr_en = dest_status | clear_file_instr;
        wr_val = clear_file_instr ? csf_status_t'(CLEAR_VALUE)
                                  : csf_status_t'(alu_result);
        new_flags = alu_flags;
        upd_mask = flag_upd;
        if (clear_file_instr) begin
            // clear-file sets zero, keeps digit carry and carry as they were
            new_flags = '{zero: 1'b1,
                          digit_carry: cpu_status_q.digit_carry_flag,
                          carry: cpu_status_q.carry_flag};
            upd_mask = '1;
        end
        cpu_status_d = cpu_status_q;
        if (wr_en) begin
            // written like any file register; reset-cause bits left out
            cpu_status_d[IBS_POS:RP_LO_POS] = wr_val[IBS_POS:RP_LO_POS];
            cpu_status_d[Z_POS:C_POS] = wr_val[Z_POS:C_POS];
        end
        // flag update overrides the written value of the same bit
        if (upd_mask.zero) begin
            cpu_status_d.zero_flag = new_flags.zero;
        end
        if (upd_mask.digit_carry) begin
            cpu_status_d.digit_carry_flag = new_flags.digit_carry;
        end
        if (upd_mask.carry) begin
            cpu_status_d.carry_flag = new_flags.carry;
        end
        // time-out event outranks the instructions that set the bit
        if (cause.power_up) begin
            cpu_status_d.timeout_flag = 1'b1;
            cpu_status_d.powerdown_flag = 1'b1;
        end else if (cause.wdt_timeout) begin
            cpu_status_d.timeout_flag = 1'b0;
        end else if (cause.sleep) begin
            cpu_status_d.timeout_flag = 1'b1;
            cpu_status_d.powerdown_flag = 1'b0;
        end else if (cause.wdt_clear) begin
            cpu_status_d.timeout_flag = 1'b1;
            cpu_status_d.powerdown_flag = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cpu_status_q <= csf_status_t'(STATUS_RESET);
        end else begin
            cpu_status_q <= cpu_status_d;
        end
    end

    // bank decode is combinational so the current cycle's operand resolves
    always_comb begin
        direct_addr = {cpu_status_q.direct_bank_select_hi,
                       cpu_status_q.direct_bank_select_lo,
                       direct_offset};
        indirect_addr = {cpu_status_q.indirect_bank_select,
                         indirect_ptr};
    end

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    logic no_cause;
    assign no_cause = (cause == '0);

    sequence s_clear_issued;
        clear_file_instr && no_cause;
    endsequence

    sequence s_clear_result;
        cpu_status_q[IBS_POS:RP_LO_POS] == 3'h0 && cpu_status_q.zero_flag;
    endsequence

    property p_layout;
        $rose(cpu_status_q.timeout_flag) |->
            cpu_status_q[TMO_POS] && $past(cause.power_up || cause.sleep
                || cause.wdt_clear);
    endproperty
    a_layout: assert property (p_layout)
        else $error("time-out bit rose without a cause");

    property p_plain_write;
        dest_status && !clear_file_instr && flag_upd == '0 |=>
            cpu_status_q[IBS_POS:RP_LO_POS] ==
                $past(alu_result[IBS_POS:RP_LO_POS])
            && cpu_status_q[Z_POS:C_POS] == $past(alu_result[Z_POS:C_POS]);
    endproperty
    a_plain_write: assert property (p_plain_write)
        else $error("status write did not store the result");

    property p_flag_override;
        dest_status && !clear_file_instr && flag_upd == 3'h7 |=>
            cpu_status_q.zero_flag == $past(alu_flags.zero)
            && cpu_status_q.digit_carry_flag == $past(alu_flags.digit_carry)
            && cpu_status_q.carry_flag == $past(alu_flags.carry);
    endproperty
    a_flag_override: assert property (p_flag_override)
        else $error("written flags not replaced by alu flags");

    property p_cause_protected;
        no_cause |=> $stable(cpu_status_q.timeout_flag)
            && $stable(cpu_status_q.powerdown_flag);
    endproperty
    a_cause_protected: assert property (p_cause_protected)
        else $error("reset-cause bit changed by an instruction");

    property p_clear_file;
        logic [1:0] keep;
        (s_clear_issued, keep = {cpu_status_q.digit_carry_flag,
                                 cpu_status_q.carry_flag})
            |=> s_clear_result ##0
            {cpu_status_q.digit_carry_flag, cpu_status_q.carry_flag} == keep;
    endproperty
    a_clear_file: assert property (p_clear_file)
        else $error("clear-file gave the wrong status value");

    property p_borrow;
        alu_op == CSF_OP_SUB |->
            alu_flags.carry == (alu_a >= alu_b)
            && alu_flags.digit_carry ==
                (alu_a[NIBBLE_W-1:0] >= alu_b[NIBBLE_W-1:0]);
    endproperty
    a_borrow: assert property (p_borrow)
        else $error("subtraction borrow polarity wrong");

    property p_direct_bank;
        direct_addr[BANK_ADDR_W-1:DIRECT_OFF_W] ==
            cpu_status_q[RP_HI_POS:RP_LO_POS]
        && direct_addr[DIRECT_OFF_W-1:0] == direct_offset;
    endproperty
    a_direct_bank: assert property (p_direct_bank)
        else $error("direct bank address wrong");

    property p_carry;
        alu_op == CSF_OP_ADD |->
            alu_flags.carry ==
                (({1'b0, alu_a} + {1'b0, alu_b}) > 9'h0ff);
    endproperty
    a_carry: assert property (p_carry)
        else $error("addition carry wrong");

    property p_indirect_bank;
        indirect_addr[BANK_ADDR_W-1] == cpu_status_q[IBS_POS]
        && indirect_addr[INDIRECT_PTR_W-1:0] == indirect_ptr;
    endproperty
    a_indirect_bank: assert property (p_indirect_bank)
        else $error("indirect bank address wrong");

    property p_timeout;
        cause.wdt_timeout && !cause.power_up |=>
            !cpu_status_q.timeout_flag;
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("time-out bit not cleared by watchdog time-out");

    property p_sleep;
        cause == 4'h2 |=> cpu_status_q.timeout_flag
            && !cpu_status_q.powerdown_flag;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("sleep did not set time-out and clear power-down");

    property p_power_up;
        cause.power_up |=> cpu_status_q.timeout_flag
            && cpu_status_q.powerdown_flag;
    endproperty
    a_power_up: assert property (p_power_up)
        else $error("power-up did not set both reset-cause bits");

endmodule : csf_status_reg

// File: tb/tb_cpu_status_flag_register.sv
// self-checking bench for the cpu status flag register
// assumes csf_pkg and csf_status_reg are compiled first; one clock
`timescale 1ns/1ps
module tb_cpu_status_flag_register;
    import csf_pkg::*;

    logic ref_clk;
    logic rst;
    logic [7:0] alu_a;
    logic [7:0] alu_b;
    csf_alu_op_t alu_op;
    csf_flags_t flag_upd;
    logic dest_status;
    logic clear_file_instr;
    csf_cause_t cause;
    logic [6:0] direct_offset;
    logic [7:0] indirect_ptr;
    csf_status_t cpu_status_q;
    logic [7:0] alu_result;
    csf_flags_t alu_flags;
    logic [8:0] direct_addr;
    logic [8:0] indirect_addr;
    logic [8:0] st;
    logic [8:0] res_s;
    logic [8:0] fl_s;
    int error_cnt;
    int cmp_count;

    assign st = {1'b0, cpu_status_q};

    csf_status_reg u_dut (
        .ref_clk(ref_clk), .rst(rst), .alu_a(alu_a), .alu_b(alu_b),
        .alu_op(alu_op), .flag_upd(flag_upd), .dest_status(dest_status),
        .clear_file_instr(clear_file_instr), .cause(cause),
        .direct_offset(direct_offset), .indirect_ptr(indirect_ptr),
        .cpu_status_q(cpu_status_q), .alu_result(alu_result),
        .alu_flags(alu_flags), .direct_addr(direct_addr),
        .indirect_addr(indirect_addr)
    );

    always #2.5 ref_clk = ~ref_clk;

    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk

    task automatic results();
        $display("checks %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    // one instruction: alu outputs sampled before the taking edge
    task automatic instr(input csf_alu_op_t op, input logic [7:0] a,
            input logic [7:0] b, input logic [2:0] fu, input logic dst,
            input logic clr, input logic [3:0] cs);
        @(posedge ref_clk);
        alu_op <= op;
        alu_a <= a;
        alu_b <= b;
        flag_upd <= csf_flags_t'(fu);
        dest_status <= dst;
        clear_file_instr <= clr;
        cause <= csf_cause_t'(cs);
        #1;
        res_s = {1'b0, alu_result};
        fl_s = {6'h00, alu_flags};
        @(posedge ref_clk);
        flag_upd <= '0;
        dest_status <= 1'b0;
        clear_file_instr <= 1'b0;
        cause <= '0;
        #1;
    endtask : instr

    task automatic t_write();
        instr(CSF_OP_PASS, 8'hff, 8'h00, 3'b000, 1'b1, 1'b0, 4'h0);
        chk(st, 9'h0ff);
        instr(CSF_OP_PASS, 8'h00, 8'h00, 3'b000, 1'b0, 1'b0, 4'h1);
        chk(st, 9'h0ef);
        instr(CSF_OP_PASS, 8'hff, 8'h00, 3'b000, 1'b1, 1'b0, 4'h0);
        chk(st, 9'h0ef);
        instr(CSF_OP_PASS, 8'h00, 8'h00, 3'b000, 1'b1, 1'b0, 4'h0);
        chk(st, 9'h008);
        instr(CSF_OP_PASS, 8'h00, 8'h00, 3'b000, 1'b0, 1'b0, 4'h8);
        chk(st, 9'h018);
    endtask : t_write

    task automatic t_arith();
        // written byte is zero, so stored flags can only come from the alu
        instr(CSF_OP_ADD, 8'hff, 8'h01, 3'b111, 1'b1, 1'b0, 4'h0);
        chk(res_s, 9'h000);
        chk(fl_s, 9'h007);
        chk(st, 9'h01f);
        instr(CSF_OP_ADD, 8'h0f, 8'h01, 3'b111, 1'b0, 1'b0, 4'h0);
        chk(st, 9'h01a);
        instr(CSF_OP_SUB, 8'h10, 8'h01, 3'b111, 1'b0, 1'b0, 4'h0);
        chk(res_s, 9'h00f);
        chk(st, 9'h019);
        instr(CSF_OP_SUB, 8'h01, 8'h02, 3'b001, 1'b0, 1'b0, 4'h0);
        chk(fl_s, 9'h000);
        chk(st, 9'h018);
        instr(CSF_OP_SUB, 8'h05, 8'h05, 3'b010, 1'b0, 1'b0, 4'h0);
        chk(st, 9'h01a);
        instr(CSF_OP_AND, 8'hf0, 8'h0f, 3'b100, 1'b0, 1'b0, 4'h0);
        chk(st, 9'h01e);
        instr(CSF_OP_XOR, 8'hc5, 8'h3c, 3'b100, 1'b0, 1'b0, 4'h0);
        chk(res_s, 9'h0f9);
        instr(CSF_OP_IOR, 8'hc5, 8'h3c, 3'b000, 1'b0, 1'b0, 4'h0);
        chk(res_s, 9'h0fd);
    endtask : t_arith

    task automatic t_clear();
        instr(CSF_OP_PASS, 8'he3, 8'h00, 3'b000, 1'b1, 1'b0, 4'h0);
        chk(st, 9'h0fb);
        // competing flag update (all zero) must lose to the clear
        instr(CSF_OP_SUB, 8'h01, 8'h02, 3'b111, 1'b1, 1'b1, 4'h0);
        chk(st, 9'h01f);
        // a move leaves the flags exactly as written
        instr(CSF_OP_PASS, 8'h43, 8'h00, 3'b000, 1'b1, 1'b0, 4'h0);
        chk(st, 9'h05b);
    endtask : t_clear

    task automatic t_bank();
        for (int i = 0; i < 8; i++) begin
            direct_offset <= 7'h2a ^ 7'(i);
            indirect_ptr <= 8'hc3 ^ 8'(i);
            instr(CSF_OP_PASS, {3'(i), 5'h00}, 8'h00, 3'b000, 1'b1, 1'b0,
                4'h0);
            chk(direct_addr, {2'(i), 7'h2a ^ 7'(i)});
            chk(indirect_addr, {i[2], 8'hc3 ^ 8'(i)});
        end
    endtask : t_bank

    task automatic t_cause();
        logic [3:0] ev [6] = '{4'h1, 4'h2, 4'h1, 4'h4, 4'h3, 4'h9};
        logic [8:0] ex [6] = '{9'h1, 9'h2, 9'h0, 9'h3, 9'h1, 9'h3};
        for (int i = 0; i < 6; i++) begin
            instr(CSF_OP_PASS, 8'h00, 8'h00, 3'b000, 1'b0, 1'b0, ev[i]);
            chk({7'h00, cpu_status_q[4:3]}, ex[i]);
        end
    endtask : t_cause

    initial begin
        repeat (5000) @(posedge ref_clk);
        error_cnt++;
        results();
    end

    initial begin
        ref_clk = 1'b0;
        rst = 1'b1;
        alu_a = '0;
        alu_b = '0;
        alu_op = CSF_OP_PASS;
        flag_upd = '0;
        dest_status = 1'b0;
        clear_file_instr = 1'b0;
        cause = '0;
        direct_offset = '0;
        indirect_ptr = '0;
        error_cnt = 0;
        cmp_count = 0;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        chk(st, 9'h018);
        t_write();
        t_arith();
        t_clear();
        t_bank();
        t_cause();
        results();
    end

endmodule : tb_cpu_status_flag_register
